// ==== common/spi_option_pkg.sv ====
// Constants, register layout and state carrier of the serial option-control block.
// Assumes a byte-wide register port with a small address space.
package spi_option_pkg;

  // ---------------------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] OPT_OFFSET    = 3'h1;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 3'h4;
  localparam logic [ADDR_W-1:0] MASK_OFFSET   = 3'h5;
  localparam logic [ADDR_W-1:0] PINS_OFFSET   = 3'h6;

  // ---------------------------------------------------------------------------
  // Option control field positions
  // ---------------------------------------------------------------------------
  localparam int unsigned OPT_MATCH_IRQ_EN  = 7;
  localparam int unsigned OPT_WIDTH_SELECT  = 6;
  localparam int unsigned OPT_MODE_FAULT_EN = 4;
  localparam int unsigned OPT_BIDIR_OE      = 3;
  localparam int unsigned OPT_WAIT_STOP     = 1;
  localparam int unsigned OPT_SINGLE_WIRE   = 0;

  localparam logic [DATA_W-1:0] OPT_RESET      = 8'h00;
  // Positions 5 and 2 are reserved: never stored, read as zero
  localparam logic [DATA_W-1:0] OPT_WRITE_MASK = 8'hdb;

  // ---------------------------------------------------------------------------
  // Event status / mask layout
  // ---------------------------------------------------------------------------
  localparam int unsigned EVT_W          = 4;
  localparam int unsigned EVT_XFER_DONE  = 0;
  localparam int unsigned EVT_MODE_FAULT = 1;
  localparam int unsigned EVT_ABORT      = 2;
  localparam int unsigned EVT_MATCH      = 3;
  localparam logic [EVT_W-1:0] EVT_RESET = 4'h0;

  // ---------------------------------------------------------------------------
  // Transfer framing
  // ---------------------------------------------------------------------------
  localparam int unsigned CNT_W = 6;
  // Two link clock edges per bit
  localparam logic [CNT_W-1:0] EDGES_8  = 6'h10;
  localparam logic [CNT_W-1:0] EDGES_16 = 6'h20;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 6'h01;

  typedef enum logic [0:0] {
    XFER_IDLE = 1'b0,
    XFER_BUSY = 1'b1
  } xfer_state_t;

  typedef struct packed {
    logic ss;
    logic mosi;
    logic miso;
    logic sck;
  } pin_in_t;

  typedef struct packed {
    logic ss_o;
    logic ss_oe_n;
    logic mosi_o;
    logic mosi_oe_n;
    logic miso_o;
    logic miso_oe_n;
  } pin_out_t;

  typedef struct packed {
    logic [DATA_W-1:0] opt;
    logic [EVT_W-1:0]  status;
    logic [EVT_W-1:0]  mask;
    xfer_state_t       xfer;
    logic [CNT_W-1:0]  edges;
    logic              sck_prev;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic              match_irq;
    pin_out_t          pins;
    logic              serial_in;
    logic              slave_selected;
    logic              ss_gpio;
    logic              status_reset;
    logic              clk_run;
    logic              width_16;
  } opt_state_t;

endpackage : spi_option_pkg

// ==== verilog/spi_pin_sync.sv ====
// Two-stage (or deeper) synchroniser for pins arriving from outside the clock domain.
// Assumes nothing of the inputs' timing; only the last stage may be read.
`timescale 1ns/1ps
`default_nettype none

module spi_pin_sync #(
  parameter int unsigned STAGES = 2,
  parameter int unsigned WIDTH  = 4
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  if (STAGES < 2) begin : g_bad_stages
    $error("spi_pin_sync needs at least two stages");
  end

  logic [WIDTH-1:0] stage_q [STAGES];

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_q[i] <= '0;
      end
    end else if (ce_i) begin
      stage_q[0] <= async_i;
      for (int i = 1; i < STAGES; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign sync_o = stage_q[STAGES-1];

endmodule : spi_pin_sync

`default_nettype wire

// ==== verilog/spi_option_control.sv ====
// Option control of the serial unit: option register, width, pin routing,
// slave-select function, wait clock stop and event interrupts.
// Assumes master select and select-output enable come from the first control
// register on the same clock; the shifter supplies serial output data.
//
// Functional notes
// - Match flag with enable raises interrupt
// - Width bit sizes transfers 8 or 16
// - Master width change aborts, idles, sets status to that cycle's events
// - Slave ignores mode fault enable; select input
// - Master without fault enable releases select pin
// - Master with fault enable uses select pin
// - Output enable picks fault input or output
// - Master select low slave, high master
// - Bidir enable only matters in single-wire
// - Single-wire: enable drives pin, else input
// - Wait stop bit halts clocks in wait
// - Normal mode uses separate data pins
// - Single-wire master uses only MOSI
// - Single-wire slave uses only MISO
// - Option register readable and writable at one
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module spi_option_control
  import spi_option_pkg::*;
#(
  parameter int unsigned SYNC_STAGES = 2
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  // Register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // Neighbouring control and status logic
  input  wire logic              master_select_i,
  input  wire logic              select_output_enable_i,
  input  wire logic              receive_match_flag_i,
  input  wire logic              wait_mode_i,
  input  wire logic              serial_out_i,
  output logic                   serial_in_o,
  output logic                   width_16_o,
  output logic                   status_reset_o,
  output logic                   clk_run_o,
  output logic                   slave_selected_o,
  output logic                   ss_gpio_o,
  output logic                   match_irq_o,
  output logic                   irq_o,
  // Serial pins
  input  wire logic              sck_i,
  input  wire logic              ss_i,
  output logic                   ss_o,
  output logic                   ss_oe_n_o,
  input  wire logic              mosi_i,
  output logic                   mosi_o,
  output logic                   mosi_oe_n_o,
  input  wire logic              miso_i,
  output logic                   miso_o,
  output logic                   miso_oe_n_o
);

  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("spi_option_control needs SYNC_STAGES of at least two");
  end

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  pin_in_t pin_async;
  pin_in_t pin_sync;

  assign pin_async = '{ss: ss_i, mosi: mosi_i, miso: miso_i, sck: sck_i};

  spi_pin_sync #(
    .STAGES (SYNC_STAGES),
    .WIDTH  ($bits(pin_in_t))
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .async_i (pin_async),
    .sync_o  (pin_sync)
  );

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  opt_state_t s_q;
  opt_state_t s_d;

  localparam opt_state_t STATE_RESET = '{
    opt:            OPT_RESET,
    status:         EVT_RESET,
    mask:           EVT_RESET,
    xfer:           XFER_IDLE,
    edges:          CNT_ZERO,
    sck_prev:       1'b0,
    rdata:          '0,
    irq:            1'b0,
    match_irq:      1'b0,
    pins:           '{ss_o: 1'b1, ss_oe_n: 1'b1, mosi_o: 1'b0, mosi_oe_n: 1'b1,
                      miso_o: 1'b0, miso_oe_n: 1'b1},
    serial_in:      1'b0,
    slave_selected: 1'b0,
    ss_gpio:        1'b0,
    status_reset:   1'b0,
    clk_run:        1'b1,
    width_16:       1'b0
  };

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  logic [DATA_W-1:0] opt_wr;
  logic              width_change;
  logic              fault_en;
  logic              single_wire;
  logic              bidir_oe;
  logic              sck_edge;
  logic              xfer_done;
  logic              mode_fault;
  logic [CNT_W-1:0]  edges_needed;
  logic [EVT_W-1:0]  evt_set;
  logic [EVT_W-1:0]  evt_clr;

  always_comb begin
    s_d          = s_q;
    opt_wr       = s_q.opt;
    width_change = 1'b0;
    sck_edge     = 1'b0;
    xfer_done    = 1'b0;
    mode_fault   = 1'b0;
    evt_set      = '0;
    evt_clr      = '0;

    // Register writes
    if (wr_i && addr_i == OPT_OFFSET) begin
      opt_wr = wdata_i & OPT_WRITE_MASK;
    end
    if (wr_i && addr_i == STATUS_OFFSET) begin
      evt_clr = wdata_i[EVT_W-1:0];
    end
    if (wr_i && addr_i == MASK_OFFSET) begin
      s_d.mask = wdata_i[EVT_W-1:0];
    end
    s_d.opt = opt_wr;

    fault_en    = s_d.opt[OPT_MODE_FAULT_EN];
    single_wire = s_d.opt[OPT_SINGLE_WIRE];
    bidir_oe    = s_d.opt[OPT_BIDIR_OE] & single_wire;

    // Only a master aborts on a width change; a slave follows its partner
    width_change = master_select_i &&
                   (opt_wr[OPT_WIDTH_SELECT] != s_q.opt[OPT_WIDTH_SELECT]);

    // Clock stop in wait mode freezes framing of the link
    s_d.clk_run = !(wait_mode_i && s_d.opt[OPT_WAIT_STOP]);

    // Transfer framing from link clock edges
    s_d.width_16 = s_d.opt[OPT_WIDTH_SELECT];
    edges_needed = s_d.width_16 ? EDGES_16 : EDGES_8;
    s_d.sck_prev = pin_sync.sck;
    sck_edge     = s_q.clk_run && (pin_sync.sck != s_q.sck_prev);

    case (s_q.xfer)
      XFER_IDLE: begin
        if (sck_edge) begin
          s_d.xfer  = XFER_BUSY;
          s_d.edges = CNT_ONE;
        end
      end
      XFER_BUSY: begin
        if (sck_edge) begin
          s_d.edges = s_q.edges + CNT_ONE;
          if (s_d.edges >= edges_needed) begin
            s_d.xfer  = XFER_IDLE;
            s_d.edges = CNT_ZERO;
            xfer_done = 1'b1;
          end
        end
      end
      default: begin
        s_d.xfer  = XFER_IDLE;
        s_d.edges = CNT_ZERO;
      end
    endcase

    s_d.status_reset = width_change;
    if (width_change) begin
      s_d.xfer  = XFER_IDLE;
      s_d.edges = CNT_ZERO;
    end

    // Slave-select pin function
    s_d.pins.ss_o      = 1'b1;
    s_d.pins.ss_oe_n   = 1'b1;
    s_d.ss_gpio        = 1'b0;
    s_d.slave_selected = 1'b0;
    if (!master_select_i) begin
      s_d.slave_selected = !pin_sync.ss;
    end else if (!fault_en) begin
      s_d.ss_gpio = 1'b1;
    end else if (!select_output_enable_i) begin
      mode_fault = !pin_sync.ss;
    end else begin
      s_d.pins.ss_oe_n = 1'b0;
      s_d.pins.ss_o    = !(s_d.xfer == XFER_BUSY);
    end

    // Data pin routing
    s_d.pins.mosi_o    = serial_out_i;
    s_d.pins.miso_o    = serial_out_i;
    s_d.pins.mosi_oe_n = 1'b1;
    s_d.pins.miso_oe_n = 1'b1;
    if (!single_wire) begin
      if (master_select_i) begin
        s_d.pins.mosi_oe_n = 1'b0;
        s_d.serial_in      = pin_sync.miso;
      end else begin
        s_d.pins.miso_oe_n = 1'b0;
        s_d.serial_in      = pin_sync.mosi;
      end
    end else if (master_select_i) begin
      s_d.pins.mosi_oe_n = !bidir_oe;
      s_d.serial_in      = pin_sync.mosi;
    end else begin
      s_d.pins.miso_oe_n = !bidir_oe;
      s_d.serial_in      = pin_sync.miso;
    end

    // Sticky events: a set in the same cycle as its clear wins
    evt_set[EVT_XFER_DONE]  = xfer_done;
    evt_set[EVT_MODE_FAULT] = mode_fault;
    evt_set[EVT_ABORT]      = width_change;
    evt_set[EVT_MATCH]      = receive_match_flag_i;
    if (width_change) begin
      s_d.status = evt_set;
    end else begin
      s_d.status = (s_q.status & ~evt_clr) | evt_set;
    end

    s_d.match_irq = s_d.opt[OPT_MATCH_IRQ_EN] & receive_match_flag_i;
    s_d.irq       = |(s_d.status & s_d.mask);

    // Read data stand in the cycle after the strobe only
    s_d.rdata = '0;
    if (rd_i) begin
      case (addr_i)
        OPT_OFFSET:    s_d.rdata = s_q.opt & OPT_WRITE_MASK;
        STATUS_OFFSET: s_d.rdata = {{(DATA_W-EVT_W){1'b0}}, s_q.status};
        MASK_OFFSET:   s_d.rdata = {{(DATA_W-EVT_W){1'b0}}, s_q.mask};
        PINS_OFFSET:   s_d.rdata = {{(DATA_W-4){1'b0}}, pin_sync};
        default:       s_d.rdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= STATE_RESET;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign rdata_o          = s_q.rdata;
  assign serial_in_o      = s_q.serial_in;
  assign width_16_o       = s_q.width_16;
  assign status_reset_o   = s_q.status_reset;
  assign clk_run_o        = s_q.clk_run;
  assign slave_selected_o = s_q.slave_selected;
  assign ss_gpio_o        = s_q.ss_gpio;
  assign match_irq_o      = s_q.match_irq;
  assign irq_o            = s_q.irq;
  assign ss_o             = s_q.pins.ss_o;
  assign ss_oe_n_o        = s_q.pins.ss_oe_n;
  assign mosi_o           = s_q.pins.mosi_o;
  assign mosi_oe_n_o      = s_q.pins.mosi_oe_n;
  assign miso_o           = s_q.pins.miso_o;
  assign miso_oe_n_o      = s_q.pins.miso_oe_n;

endmodule : spi_option_control

`default_nettype wire

// ==== sim/spi_far_end.sv ====
// Far-end serial device: frames of sck edges with select and data lines.
// Assumes run_i is raised for one frame and held until busy_o rises.
`timescale 1ns/1ps
`default_nettype none
module spi_far_end (
  input  wire logic       run_i,
  input  wire logic [5:0] edges_i,
  input  wire logic       slow_i,
  output logic            sck_o,
  output logic            ss_n_o,
  output logic            mosi_o,
  output logic            miso_o,
  output logic            busy_o
);
  logic [7:0] pat;
  initial begin
    {sck_o, busy_o, mosi_o, miso_o} = 4'h0;
    ss_n_o = 1'b1;
    pat = 8'h96;
    forever begin
      @(posedge run_i);
      busy_o = 1'b1;
      ss_n_o = 1'b0;
      // Keeps every link edge off the sampling clock edge
      #3;
      for (int k = 0; k < edges_i; k++) begin
        #(slow_i ? 120 : 40);
        sck_o = ~sck_o;
        pat = {pat[6:0], pat[7]};
        mosi_o = pat[7];
        miso_o = pat[0];
      end
      #40;
      ss_n_o = 1'b1;
      // Released lines flip so a stale bit is never mistaken for data
      mosi_o = ~mosi_o;
      miso_o = ~miso_o;
      busy_o = 1'b0;
    end
  end
endmodule : spi_far_end
`default_nettype wire

// ==== sim/spi_option_control_asserts.sv ====
// Checker for the option-control block: readback, pin direction, abort pulse.
// Assumes it is bound to the option-control module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module spi_option_control_asserts
  import spi_option_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  input wire logic              ce_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              master_select_i,
  input wire logic              select_output_enable_i,
  input wire logic              receive_match_flag_i,
  input wire logic              wait_mode_i,
  input wire logic              width_16_o,
  input wire logic              status_reset_o,
  input wire logic              clk_run_o,
  input wire logic              ss_gpio_o,
  input wire logic              match_irq_o,
  input wire logic              ss_oe_n_o,
  input wire logic              mosi_oe_n_o,
  input wire logic              miso_oe_n_o
);
  logic [DATA_W-1:0] opt_q;
  logic [2:0]        oe_q;
  // Option value the design acts on in this cycle, a write in flight included
  wire logic [DATA_W-1:0] opt_n = (wr_i && addr_i == OPT_OFFSET) ?
                                  (wdata_i & OPT_WRITE_MASK) : opt_q;
  wire logic         sw = opt_n[OPT_SINGLE_WIRE] && !opt_n[OPT_BIDIR_OE];
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      opt_q <= OPT_RESET;
      oe_q  <= 3'h7;
    end else if (ce_i) begin
      oe_q[2] <= !(master_select_i && opt_n[OPT_MODE_FAULT_EN] && select_output_enable_i);
      oe_q[1] <= master_select_i ? sw : 1'b1;
      oe_q[0] <= master_select_i ? 1'b1 : sw;
      if (wr_i && addr_i == OPT_OFFSET) begin
        opt_q <= wdata_i & OPT_WRITE_MASK;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence width_write;
    ce_i && wr_i && addr_i == OPT_OFFSET && master_select_i
      && (wdata_i[OPT_WIDTH_SELECT] != opt_q[OPT_WIDTH_SELECT]);
  endsequence
  sequence reset_pulse;
    status_reset_o ##1 !status_reset_o;
  endsequence
  chk_width_abort: assert property (width_write |-> ##[1:2] reset_pulse)
    else $error("width change did not pulse status reset");
  chk_rdata_idle: assert property (ce_i && !rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside read");
  chk_opt_read: assert property (ce_i && rd_i && addr_i == OPT_OFFSET |=> rdata_o == $past(opt_q))
    else $error("option readback wrong");
  chk_width_level: assert property (ce_i |=> width_16_o == $past(opt_n[OPT_WIDTH_SELECT]))
    else $error("width level wrong");
  chk_match_irq: assert property (ce_i |=> match_irq_o ==
    ($past(receive_match_flag_i) && $past(opt_n[OPT_MATCH_IRQ_EN])))
    else $error("match interrupt wrong");
  chk_clk_stop: assert property (ce_i |=> clk_run_o ==
    !($past(wait_mode_i) && $past(opt_n[OPT_WAIT_STOP])))
    else $error("clock run wrong");
  chk_ss_release: assert property (ce_i |=> ss_gpio_o ==
    ($past(master_select_i) && !$past(opt_n[OPT_MODE_FAULT_EN])))
    else $error("select pin release wrong");
  chk_ss_dir: assert property (ss_oe_n_o == oe_q[2])
    else $error("select pin direction wrong");
  chk_mosi_dir: assert property (mosi_oe_n_o == oe_q[1])
    else $error("mosi direction wrong");
  chk_miso_dir: assert property (miso_oe_n_o == oe_q[0])
    else $error("miso direction wrong");
endmodule : spi_option_control_asserts
bind spi_option_control spi_option_control_asserts u_chk (
  .clk_i, .rst_n_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .master_select_i,
  .select_output_enable_i, .receive_match_flag_i, .wait_mode_i, .width_16_o,
  .status_reset_o, .clk_run_o, .ss_gpio_o, .match_irq_o, .ss_oe_n_o, .mosi_oe_n_o,
  .miso_oe_n_o
);
`default_nettype wire

// ==== sim/spi_option_control_tb_top.sv ====
// Self-checking bench: register port, pin directions, framing, abort, interrupts.
// Assumes the checker binds itself and the far end makes the 80 ns link clock, 240 ns when slow.
`timescale 1ns/1ps
`default_nettype none
module spi_option_control_tb_top
  import spi_option_pkg::*;
;
  logic              clk_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              ce_i = 1'b1;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o;
  logic              wr_i, rd_i, master_select_i, select_output_enable_i;
  logic              receive_match_flag_i, wait_mode_i, width_16_o, status_reset_o;
  logic              clk_run_o, ss_gpio_o, match_irq_o, irq_o, ss_o, ss_oe_n_o;
  logic              mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o;
  logic              p_sck, p_ss_n, p_mosi, p_miso, busy, run, slow;
  logic [5:0]        n_edges;
  int                failures, comparisons, seed, opt_m, stat_m, mask_m, edges_m, sr_cnt;
  int                ss_lo;
  wire logic         ss_w = ss_oe_n_o ? p_ss_n : ss_o;
  wire logic         mosi_w = mosi_oe_n_o ? p_mosi : mosi_o;
  wire logic         miso_w = miso_oe_n_o ? p_miso : miso_o;
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) if (status_reset_o === 1'b1) sr_cnt++;
  always @(posedge clk_i) if (ss_o === 1'b0) ss_lo++;
  spi_option_control dut (
    .clk_i, .rst_n_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .master_select_i,
    .select_output_enable_i, .receive_match_flag_i, .wait_mode_i, .serial_out_i(1'b0),
    .serial_in_o(), .width_16_o, .status_reset_o, .clk_run_o, .slave_selected_o(),
    .ss_gpio_o, .match_irq_o, .irq_o, .sck_i(p_sck), .ss_i(ss_w), .ss_o, .ss_oe_n_o,
    .mosi_i(mosi_w), .mosi_o, .mosi_oe_n_o, .miso_i(miso_w), .miso_o, .miso_oe_n_o
  );
  spi_far_end far (.run_i(run), .edges_i(n_edges), .slow_i(slow), .sck_o(p_sck),
    .ss_n_o(p_ss_n), .mosi_o(p_mosi), .miso_o(p_miso), .busy_o(busy));
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h0, got}, {7'h0, exp});
  endtask : cmp1
  task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    {wr_i, rd_i, addr_i, wdata_i} <= {w, !w, a, d};
    @(posedge clk_i);
    {wr_i, rd_i} <= 2'h0;
    #2;
  endtask : bus
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    cmp8(rdata_o, exp);
  endtask : rdc
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
    if (a == OPT_OFFSET) opt_m = d;
    if (a == STATUS_OFFSET) stat_m &= ~int'(d);
    if (a == MASK_OFFSET) mask_m = d;
  endtask : wr
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask : tick
  task automatic irq_chk();
    tick(1);
    cmp1(irq_o, (stat_m & mask_m) != 0);
  endtask : irq_chk
  task automatic frame(input int n, input logic sl);
    int k;
    int need;
    @(posedge clk_i);
    {n_edges, slow, run} <= {6'(n), sl, 1'b1};
    k = 0;
    while (busy !== 1'b1 && k < 50) begin
      @(posedge clk_i);
      k++;
    end
    run <= 1'b0;
    if (k == 50) k = 2000;
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 2000) begin
      failures++;
      close_out();
    end
    need = opt_m[OPT_WIDTH_SELECT] ? 32 : 16;
    if (!(wait_mode_i && opt_m[OPT_WAIT_STOP])) edges_m += n;
    if (edges_m >= need) begin
      stat_m |= 1;
      edges_m -= need;
    end
    tick(6);
  endtask : frame
  task automatic close_out();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  initial begin
    {wr_i, rd_i, master_select_i, select_output_enable_i, run, slow} = 6'h0;
    {receive_match_flag_i, wait_mode_i, addr_i, wdata_i, n_edges} = '0;
    {failures, comparisons, opt_m, stat_m, mask_m, edges_m, sr_cnt, ss_lo} = '0;
    seed = 32'hcc0c;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int a = 1; a < 7; a++) rdc(3'(a), (a == 6) ? 8'h08 : 8'h00);
    cmp1(clk_run_o, 1'b1);
    repeat (4) begin
      wr(OPT_OFFSET, 8'($random(seed)) & 8'hdb);
      rdc(OPT_OFFSET, 8'(opt_m));
    end
    for (int i = 0; i < 32; i++) begin
      @(posedge clk_i);
      {master_select_i, select_output_enable_i} <= {i[0], i[1]};
      wr(OPT_OFFSET, {3'h0, i[2], i[3], 2'h0, i[4]});
      tick(2);
      cmp1(mosi_oe_n_o, i[0] ? (i[4] && !i[3]) : 1'b1);
      cmp1(miso_oe_n_o, i[0] ? 1'b1 : (i[4] && !i[3]));
      cmp1(ss_oe_n_o, !(i[0] && i[1] && i[2]));
      cmp1(ss_gpio_o, i[0] && !i[2]);
    end
    @(posedge clk_i);
    master_select_i <= 1'b0;
    wr(OPT_OFFSET, 8'h00);
    rdc(STATUS_OFFSET, 8'h00);
    frame(16, 1'b0);
    rdc(STATUS_OFFSET, 8'(stat_m));
    irq_chk();
    wr(MASK_OFFSET, 8'h01);
    irq_chk();
    wr(STATUS_OFFSET, 8'h01);
    irq_chk();
    wr(OPT_OFFSET, 8'h40);
    frame(16, 1'b1);
    rdc(STATUS_OFFSET, 8'(stat_m));
    frame(16, 1'b0);
    rdc(STATUS_OFFSET, 8'(stat_m));
    wr(STATUS_OFFSET, 8'h01);
    frame(16, 1'b0);
    @(posedge clk_i);
    master_select_i <= 1'b1;
    wr(OPT_OFFSET, 8'h00);
    {stat_m, edges_m} = {32'd4, 32'd0};
    rdc(STATUS_OFFSET, 8'h04);
    cmp1(sr_cnt == 1, 1'b1);
    frame(16, 1'b0);
    rdc(STATUS_OFFSET, 8'(stat_m));
    irq_chk();
    wr(STATUS_OFFSET, 8'h05);
    @(posedge clk_i);
    {master_select_i, wait_mode_i} <= 2'h1;
    wr(OPT_OFFSET, 8'h02);
    tick(2);
    cmp1(clk_run_o, 1'b0);
    frame(16, 1'b0);
    rdc(STATUS_OFFSET, 8'(stat_m));
    wr(OPT_OFFSET, 8'h00);
    tick(2);
    cmp1(clk_run_o, 1'b1);
    @(posedge clk_i);
    {wait_mode_i, receive_match_flag_i} <= 2'h1;
    wr(OPT_OFFSET, 8'h80);
    tick(2);
    cmp1(match_irq_o, 1'b1);
    stat_m |= 8;
    rdc(STATUS_OFFSET, 8'(stat_m));
    wr(OPT_OFFSET, 8'h00);
    tick(2);
    cmp1(match_irq_o, 1'b0);
    @(posedge clk_i);
    {master_select_i, select_output_enable_i, receive_match_flag_i} <= 3'h6;
    wr(OPT_OFFSET, 8'h10);
    ss_lo = 0;
    frame(16, 1'b0);
    // Select driven low from first to sixteenth edge: 15 gaps of 4 clocks
    cmp1(ss_lo == 60, 1'b1);
    @(posedge clk_i);
    select_output_enable_i <= 1'b0;
    frame(16, 1'b0);
    stat_m |= 2;
    rdc(STATUS_OFFSET, 8'(stat_m));
    close_out();
  end
endmodule : spi_option_control_tb_top
`default_nettype wire
